//--- design/tws_pkg.sv
// Package for the two-wire address match, data port and master time-out block
package tws_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_STATUS    = 8'h1A;
   localparam logic [7:0] OFS_SYNC      = 8'h1C;
   localparam logic [7:0] OFS_OWNID     = 8'h24;
   localparam logic [7:0] OFS_DATA      = 8'h28;
   localparam logic [7:0] OFS_HOOK      = 8'h30;
   // Primary control field positions
   localparam int CTL_SWRST   = 0;
   localparam int CTL_ENABLE  = 1;
   localparam int CTL_MODE_LO = 2;
   localparam int CTL_STRETCH = 27;
   localparam int CTL_IDLE_LO = 28;
   localparam int CTL_LOWTO   = 30;
   // Writable bits of the primary control register; all others read zero
   localparam logic [31:0] CTL_WMASK    = 32'h7BF1_009F;
   localparam logic [31:0] CTL_RESET    = 32'h0000_0000;
   localparam logic [2:0]  MODE_MASTER  = 3'h5;
   // Own id register layout
   localparam logic [31:0] OWNID_WMASK  = 32'h07FE_87FF;
   localparam int OWNID_BCAST = 0;
   localparam int OWNID_LONG  = 15;
   // Status bit positions
   localparam int ST_BUSFAULT = 0;
   localparam int ST_DIR      = 3;
   localparam int ST_LOWEXP   = 6;
   localparam int ST_HOLD     = 7;
   localparam int ST_HIT      = 8;
   localparam int ST_SLAVEBUS = 9;
   localparam int ST_MASTBUS  = 10;
   localparam int ST_IDLE     = 11;
   // Timing
   localparam int  CLK_MHZ        = 100;
   localparam int  LOW_TO_MS      = 25;
   localparam int  LOW_TO_CYC     = LOW_TO_MS * 1000 * CLK_MHZ;
   localparam int  SYNC_CYC       = 3;
   localparam logic [4:0] IDLE_SCL_1 = 5'h05;
   localparam logic [4:0] IDLE_SCL_2 = 5'h0A;
   localparam logic [4:0] IDLE_SCL_3 = 5'h14;

   // Bus operation request to the bit engine
   typedef struct packed {
      logic       go;
      logic       write;
      logic       ack_nack;
      logic       stop;
   } tws_op_t;
endpackage

//--- design/tws_idle_timer.sv
// SCL low watchdog counting SCL periods and core cycles
`timescale 1ns/100ps
module tws_idle_timer
   import tws_pkg::*;
#(
   parameter int LOW_CYC = LOW_TO_CYC
)(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // Line and settings
   input  wire logic       scl_low,
   input  wire logic       scl_rise,
   input  wire logic       low_en,
   input  wire logic [1:0] idle_sel,
   input  wire logic [15:0] period_cyc,
   // Expiry pulses
   output logic            low_exp,
   output logic            idle_exp
);
   typedef struct packed {
      logic [31:0] low_cnt;
      logic [15:0] per_cnt;
      logic [4:0]  scl_cnt;
      logic        low_exp;
      logic        idle_exp;
   } tws_tmr_t;

   tws_tmr_t st_r, st_nxt;

   function automatic logic [4:0] idle_limit(input logic [1:0] s);
      case (s)
         2'h1:    idle_limit = IDLE_SCL_1;
         2'h2:    idle_limit = IDLE_SCL_2;
         2'h3:    idle_limit = IDLE_SCL_3;
         default: idle_limit = 5'h1F;
      endcase
   endfunction

   // Both counters restart on SCL high or when their time-out is off
   always_comb begin
      st_nxt          = st_r;
      st_nxt.low_exp  = 1'b0;
      st_nxt.idle_exp = 1'b0;
      if (!scl_low || !low_en) begin
         st_nxt.low_cnt = 32'h0000_0000;
      end else if (st_r.low_cnt == 32'(LOW_CYC - 1)) begin
         st_nxt.low_exp = 1'b1;
         st_nxt.low_cnt = 32'h0000_0000;
      end else begin
         st_nxt.low_cnt = st_r.low_cnt + 32'h0000_0001;
      end
      // Idle count scales with the measured SCL period
      if (!scl_low || idle_sel == 2'h0) begin
         st_nxt.per_cnt = 16'h0000;
         st_nxt.scl_cnt = 5'h00;
      end else if (st_r.per_cnt >= period_cyc) begin
         st_nxt.per_cnt = 16'h0000;
         if (st_r.scl_cnt + 5'h01 == idle_limit(idle_sel)) begin
            st_nxt.idle_exp = 1'b1;
            st_nxt.scl_cnt  = 5'h00;
         end else begin
            st_nxt.scl_cnt = st_r.scl_cnt + 5'h01;
         end
      end else begin
         st_nxt.per_cnt = st_r.per_cnt + 16'h0001;
      end
      if (scl_rise) begin
         st_nxt.per_cnt = 16'h0000;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign low_exp  = st_r.low_exp;
   assign idle_exp = st_r.idle_exp;
endmodule

//--- design/tws_core.sv
// Two-wire unit: own id match, byte data port and master time-outs
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
module tws_core
   import tws_pkg::*;
#(
   parameter int LOW_CYC = LOW_TO_CYC
)(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // Bus line samples
   input  wire logic        scl_in,
   // From the bit engine
   input  wire logic        addr_valid,
   input  wire logic [9:0]  addr_rx,
   input  wire logic        addr_long,
   input  wire logic        addr_rw,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        ack_phase,
   input  wire logic        byte_phase,
   input  wire logic        stop_seen,
   // To the bit engine
   output tws_op_t          op,
   output logic [7:0]       tx_byte,
   output logic             scl_hold,
   output logic             stop_req,
   output logic             bus_idle,
   output logic             unit_enabled,
   output logic             stretch_ack_only,
   // Settings from the command side
   input  wire logic        ack_response_choice,
   input  wire logic        auto_ack_on_access
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] ownid;
      logic [7:0]  rx_buf;
      logic [7:0]  tx_buf;
      logic        id_hit_flag;
      logic        dir;
      logic        scl_hold_flag;
      logic        slave_on_bus_flag;
      logic        master_on_bus_flag;
      logic        scl_low_expiry;
      logic        bus_fault_flag;
      logic        idle;
      logic        en_act;
      logic [1:0]  sync_cnt;
      logic        sync_pending;
      logic [2:0]  scl_sy;
      logic [15:0] per_meas;
      logic [15:0] per_cyc;
      tws_op_t     op;
      logic        stop_req;
      logic [31:0] rdata;
   } tws_st_t;

   tws_st_t st_r, st_nxt;
   logic    low_exp;
   logic    idle_exp;
   logic    scl_s;
   logic    scl_rise;
   logic    id_match;

   // Received id against own id, width chosen by the long id mode
   function automatic logic id_equal(input logic [9:0] rx, input logic [9:0] own, input logic lng);
      if (lng) begin
         id_equal = (rx == own);
      end else begin
         id_equal = (rx[6:0] == own[6:0]);
      end
   endfunction

   assign scl_s    = st_r.scl_sy[1];
   assign scl_rise = st_r.scl_sy[1] & ~st_r.scl_sy[2];
   assign id_match = (addr_long == st_r.ownid[OWNID_LONG])
                   && id_equal(addr_rx, st_r.ownid[10:1], st_r.ownid[OWNID_LONG])
                   || (st_r.ownid[OWNID_BCAST] && !addr_long
                   && addr_rx[6:0] == 7'h00 && !addr_rw);

   tws_idle_timer #(
      .LOW_CYC    (LOW_CYC)
   ) u_timer (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .scl_low    (~scl_s & st_r.en_act),
      .scl_rise   (scl_rise),
      .low_en     (st_r.ctrl[CTL_LOWTO]),
      .idle_sel   (st_r.ctrl[CTL_IDLE_LO +: 2]),
      .period_cyc (st_r.per_cyc),
      .low_exp    (low_exp),
      .idle_exp   (idle_exp)
   );

   // Next state of the whole block
   always_comb begin
      st_nxt          = st_r;
      st_nxt.op       = '0;
      st_nxt.stop_req = 1'b0;
      st_nxt.rdata    = 32'h0000_0000;
      // Pin sampling: scl_sy[0] is read only by scl_sy[1]
      st_nxt.scl_sy   = {st_r.scl_sy[1:0], scl_in};
      // SCL period measured rise to rise for idle scaling
      if (scl_rise) begin
         st_nxt.per_meas = 16'h0000;
         st_nxt.per_cyc  = st_r.per_meas;
      end else if (st_r.per_meas != 16'hFFFF) begin
         st_nxt.per_meas = st_r.per_meas + 16'h0001;
      end
      // Enable synchronization window
      if (st_r.sync_pending) begin
         if (st_r.sync_cnt == 2'(SYNC_CYC - 1)) begin
            st_nxt.sync_pending = 1'b0;
            st_nxt.en_act       = st_r.ctrl[CTL_ENABLE];
         end else begin
            st_nxt.sync_cnt = st_r.sync_cnt + 2'h1;
         end
      end
      // Id match from the bit engine
      if (addr_valid && st_r.en_act && id_match) begin
         st_nxt.id_hit_flag   = 1'b1;
         st_nxt.dir           = addr_rw;
         st_nxt.scl_hold_flag = 1'b1;
         st_nxt.idle          = 1'b0;
      end
      // Received byte lands in the buffer; hold per stretch policy
      if (rx_valid) begin
         st_nxt.rx_buf = rx_byte;
      end
      if ((ack_phase && st_r.ctrl[CTL_STRETCH]) || (byte_phase && !st_r.ctrl[CTL_STRETCH])) begin
         st_nxt.scl_hold_flag = 1'b1;
         st_nxt.master_on_bus_flag = ~st_r.dir;
         st_nxt.slave_on_bus_flag  = st_r.dir;
      end
      if (stop_seen) begin
         st_nxt.idle = 1'b1;
      end
      // Register access; hardware sets below win over software clears
      if (reg_wr && !st_r.sync_pending) begin
         case (reg_addr)
            OFS_CTRL: begin
               if (reg_wdata[CTL_SWRST]) begin
                  st_nxt.ctrl  = CTL_RESET;
                  st_nxt.ownid = 32'h0000_0000;
                  st_nxt.en_act = 1'b0;
               end else begin
                  st_nxt.ctrl = reg_wdata & CTL_WMASK;
                  if (reg_wdata[CTL_ENABLE] != st_r.ctrl[CTL_ENABLE]) begin
                     st_nxt.sync_pending = 1'b1;
                     st_nxt.sync_cnt     = 2'h0;
                  end
               end
            end
            OFS_OWNID: st_nxt.ownid = reg_wdata & OWNID_WMASK;
            OFS_STATUS: begin
               // A match in the same cycle keeps the hit flag set
               if (reg_wdata[ST_HIT] && !(addr_valid && st_r.en_act && id_match)) begin
                  st_nxt.id_hit_flag    = 1'b0;
                  st_nxt.scl_low_expiry = 1'b0;
                  st_nxt.bus_fault_flag = 1'b0;
               end
               if (reg_wdata[ST_LOWEXP]) begin
                  st_nxt.scl_low_expiry = 1'b0;
               end
               if (reg_wdata[ST_BUSFAULT]) begin
                  st_nxt.bus_fault_flag = 1'b0;
               end
            end
            OFS_DATA: begin
               // Write starts a transmit only while SCL is held, no busy without auto ack
               st_nxt.tx_buf        = reg_wdata[7:0];
               st_nxt.op.go         = st_r.scl_hold_flag;
               st_nxt.op.write      = 1'b1;
               st_nxt.scl_hold_flag = 1'b0;
               st_nxt.master_on_bus_flag = 1'b0;
            end
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            OFS_CTRL:   st_nxt.rdata = st_r.ctrl;
            OFS_OWNID:  st_nxt.rdata = st_r.ownid;
            OFS_SYNC:   st_nxt.rdata = {30'h0, st_r.sync_pending, 1'b0};
            OFS_STATUS: st_nxt.rdata = {20'h0, st_r.idle, st_r.master_on_bus_flag,
                                        st_r.slave_on_bus_flag, st_r.id_hit_flag, st_r.scl_hold_flag,
                                        st_r.scl_low_expiry, 2'h0, st_r.dir, 2'h0, st_r.bus_fault_flag};
            OFS_HOOK:   st_nxt.rdata = {30'h0, auto_ack_on_access, ack_response_choice};
            OFS_DATA: begin
               st_nxt.rdata = {24'h0, st_r.rx_buf};
               // Read acks or nacks next byte only in auto ack mode
               if (auto_ack_on_access && st_r.scl_hold_flag) begin
                  st_nxt.op.go         = 1'b1;
                  st_nxt.op.ack_nack   = ack_response_choice;
                  st_nxt.op.stop       = ack_response_choice;
                  st_nxt.scl_hold_flag = 1'b0;
                  st_nxt.slave_on_bus_flag = 1'b0;
               end
            end
            default:    st_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // Low expiry: release hold, stop, flag set, fault set
      if (low_exp) begin
         st_nxt.scl_hold_flag  = 1'b0;
         st_nxt.stop_req       = 1'b1;
         st_nxt.scl_low_expiry = 1'b1;
         st_nxt.bus_fault_flag = 1'b1;
         if (st_r.dir) begin
            st_nxt.slave_on_bus_flag = 1'b1;
         end else begin
            st_nxt.master_on_bus_flag = 1'b1;
         end
      end
      if (idle_exp) begin
         st_nxt.idle = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r      <= '0;
         st_r.idle <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign reg_rdata        = st_r.rdata;
   assign op               = st_r.op;
   assign tx_byte          = st_r.tx_buf;
   assign scl_hold         = st_r.scl_hold_flag;
   assign stop_req         = st_r.stop_req;
   assign bus_idle         = st_r.idle;
   assign unit_enabled     = st_r.en_act;
   assign stretch_ack_only = st_r.ctrl[CTL_STRETCH];
endmodule

//--- verif/tws_core_monitor.sv
// Checker for the two-wire register port, data port and master time-outs
`timescale 1ns/100ps
module tws_core_monitor
   import tws_pkg::*;
#(
   parameter int LOW_CYC = LOW_TO_CYC
)(
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rst_n,
   // Register port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Line and engine side
   input wire logic        scl_in,
   input wire tws_op_t     op,
   input wire logic        scl_hold,
   input wire logic        stop_req,
   input wire logic        unit_enabled,
   input wire logic        stretch_ack_only
);
   int low_cnt_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Raw low time; the block sees SCL two flops late, so this runs ahead of it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         low_cnt_r <= 0;
      else
         low_cnt_r <= scl_in ? 0 : low_cnt_r + 1;
   end
   // Enable write while the unit is off
   sequence s_en_wr;
      reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTL_ENABLE] && !unit_enabled;
   endsequence
   a_enable_not_early: assert property (s_en_wr |=> !unit_enabled)
      else $error("unit enabled without sync delay");
   a_enable_taken: assert property (s_en_wr |-> ##[2:6] unit_enabled)
      else $error("unit not enabled after sync");
   a_data_upper_zero: assert property ($past(reg_rd) && $past(reg_addr) == OFS_DATA |-> reg_rdata[31:8] == 24'h0)
      else $error("data port upper byte not zero");
   a_ctrl_reserved_zero: assert property ($past(reg_rd) && $past(reg_addr) == OFS_CTRL |-> (reg_rdata & ~CTL_WMASK) == 32'h0)
      else $error("control reserved bits not zero");
   a_ownid_reserved_zero: assert property ($past(reg_rd) && $past(reg_addr) == OFS_OWNID |-> (reg_rdata & ~OWNID_WMASK) == 32'h0)
      else $error("own id reserved bits not zero");
   a_stretch_from_write: assert property ($changed(stretch_ack_only) |-> $past(reg_wr) && $past(reg_addr) == OFS_CTRL && $past(reg_wdata[CTL_STRETCH]) == stretch_ack_only)
      else $error("stretch policy changed without write");
   a_op_from_access: assert property (op.go |-> $past(reg_wr || reg_rd) && $past(reg_addr) == OFS_DATA)
      else $error("bus operation without data access");
   a_stop_after_low: assert property (stop_req |-> low_cnt_r >= LOW_CYC)
      else $error("stop request before low time-out");
   a_hold_released: assert property (stop_req |-> ##[0:2] !scl_hold)
      else $error("clock hold kept after low time-out");
endmodule
bind tws_core tws_core_monitor #(.LOW_CYC(LOW_CYC)) u_tws_core_monitor (
   .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in), .op(op),
   .scl_hold(scl_hold), .stop_req(stop_req), .unit_enabled(unit_enabled),
   .stretch_ack_only(stretch_ack_only)
);

//--- verif/tws_scl_agent.sv
// SCL model of another party on the two-wire bus
`timescale 1ns/100ps
module tws_scl_agent (
   // Control from the bench
   input  wire logic frame,
   input  wire logic hold_low,
   // Line seen by the block
   output logic      scl
);
   // Clocks only within frames; outside, the pull-up wins unless we stretch
   initial begin
      scl = 1'b1;
      #3.3;
      forever begin
         if (frame) begin
            #62.5 scl = 1'b0;
            #62.5 scl = 1'b1;
         end else begin
            scl = !hold_low;
            #10;
         end
      end
   end
endmodule

//--- verif/tws_core_test.sv
// Self-checking bench for the two-wire register, data port and time-out block
`timescale 1ns/100ps
module tws_core_test;
   import tws_pkg::*;
   localparam int LCYC = 200;
   logic        clk_sys, rst_n, reg_wr, reg_rd, scl_in, frame, hold_low, dir;
   logic [7:0]  reg_addr, rx_byte, tx_byte;
   logic [31:0] reg_wdata, reg_rdata, v;
   logic        addr_valid, addr_long, addr_rw, rx_valid, ack_phase, byte_phase, stop_seen;
   logic [9:0]  addr_rx;
   logic        scl_hold, stop_req, bus_idle, unit_enabled, stretch_ack_only;
   logic        ack_choice, auto_ack;
   tws_op_t     op;
   int          err_count, check_count, cyc, n;
   // Own id, then received {id, long, rw, expected hit}
   logic [15:0] c_id [7] = '{16'h074A, 16'h074A, 16'h874A, 16'h874A, 16'h074B, 16'h074A, 16'h074B};
   logic [12:0] c_rx [7] = '{13'h012B, 13'h0130, 13'h1D2D, 13'h0D2E, 13'h0001, 13'h0000, 13'h0002};

   tws_core #(.LOW_CYC(LCYC)) u_tws_core (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
      .addr_valid(addr_valid), .addr_rx(addr_rx), .addr_long(addr_long), .addr_rw(addr_rw),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .ack_phase(ack_phase), .byte_phase(byte_phase),
      .stop_seen(stop_seen), .op(op), .tx_byte(tx_byte), .scl_hold(scl_hold), .stop_req(stop_req),
      .bus_idle(bus_idle), .unit_enabled(unit_enabled), .stretch_ack_only(stretch_ack_only),
      .ack_response_choice(ack_choice), .auto_ack_on_access(auto_ack));
   tws_scl_agent u_tws_scl_agent (.frame(frame), .hold_low(hold_low), .scl(scl_in));

   // Clock and a hang guard
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Register port cycles; read data stands only in the cycle after the strobe
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic send_id(logic [9:0] a, logic lg, logic rw);
      @(posedge clk_sys);
      addr_valid <= 1'b1;
      addr_rx <= a;
      addr_long <= lg;
      addr_rw <= rw;
      @(posedge clk_sys);
      addr_valid <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      {rst_n, reg_wr, reg_rd, addr_valid, addr_long, addr_rw, rx_valid, ack_phase} = '0;
      {byte_phase, stop_seen, frame, hold_low, dir, ack_choice, auto_ack} = '0;
      {reg_addr, reg_wdata, addr_rx, rx_byte} = '0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(OFS_CTRL);
      chk("ctrl reset", v, CTL_RESET);
      rd(OFS_DATA);
      chk("data reset", v, 32'h0);
      rd(8'h3C);
      chk("unmapped", v, 32'h0);
      chk("idle at reset", bus_idle, 1'b1);
      wr(OFS_OWNID, 32'hFFFF_FFFF);
      rd(OFS_OWNID);
      chk("own id mask", v, OWNID_WMASK);
      $display("reset test done");
      // Master mode with enable; sync must show, then clear
      wr(OFS_CTRL, {27'h0, MODE_MASTER, 2'b10});
      rd(OFS_SYNC);
      chk("sync busy", v, 32'h2);
      chk("not yet enabled", unit_enabled, 1'b0);
      repeat (4) @(posedge clk_sys);
      #1 chk("enabled", unit_enabled, 1'b1);
      rd(OFS_SYNC);
      chk("sync done", v, 32'h0);
      $display("enable test done");
      wr(OFS_CTRL, 32'hFFFF_FFFE);
      #1 chk("stretch on", stretch_ack_only, 1'b1);
      repeat (5) @(posedge clk_sys);
      rd(OFS_CTRL);
      chk("ctrl mask", v, CTL_WMASK & 32'hFFFF_FFFE);
      wr(OFS_CTRL, 32'h16);
      #1 chk("stretch off", stretch_ack_only, 1'b0);
      repeat (5) @(posedge clk_sys);
      $display("control test done");
      for (int i = 0; i < 7; i++) begin
         wr(OFS_OWNID, {16'h0, c_id[i]});
         wr(OFS_STATUS, 32'h100);
         send_id(c_rx[i][12:3], c_rx[i][2], c_rx[i][1]);
         if (c_rx[i][0]) dir = c_rx[i][1];
         rd(OFS_STATUS);
         chk("id hit", v[ST_HIT], c_rx[i][0]);
         chk("direction", v[ST_DIR], dir);
      end
      $display("id match test done");
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_byte <= 8'hC3;
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      rd(OFS_DATA);
      chk("rx byte", v, 32'hC3);
      chk("no op without auto ack", op.go, 1'b0);
      rd(OFS_SYNC);
      chk("no busy", v, 32'h0);
      // Auto ack read during hold sends a nack and stop
      ack_choice <= 1'b1;
      auto_ack <= 1'b1;
      rd(OFS_DATA);
      chk("auto read op", {op.go, op.ack_nack, op.stop}, 3'h7);
      chk("hold released by read", scl_hold, 1'b0);
      auto_ack <= 1'b0;
      @(posedge clk_sys);
      byte_phase <= 1'b1;
      @(posedge clk_sys);
      byte_phase <= 1'b0;
      @(posedge clk_sys);
      #1 chk("hold at byte end", scl_hold, 1'b1);
      wr(OFS_DATA, 32'h0000_AB5A);
      #1 chk("tx byte", tx_byte, 8'h5A);
      chk("write op", {op.go, op.write}, 2'h3);
      $display("data test done");
      // Low time-out: off first, then on with SCL still stretched
      hold_low <= 1'b1;
      @(posedge clk_sys);
      ack_phase <= 1'b1;
      @(posedge clk_sys);
      ack_phase <= 1'b0;
      n = 0;
      repeat (LCYC + 50) @(posedge clk_sys) n += stop_req;
      chk("no expiry when off", n, 0);
      wr(OFS_CTRL, 32'h4000_0016);
      n = 0;
      while (stop_req !== 1'b1 && n < LCYC + 50) @(posedge clk_sys) #1 n++;
      chk("expiry seen", stop_req, 1'b1);
      chk("expiry not early", n >= LCYC - 2, 1'b1);
      repeat (3) @(posedge clk_sys);
      #1 chk("hold released", scl_hold, 1'b0);
      rd(OFS_STATUS);
      chk("low expiry flag", v[ST_LOWEXP], 1'b1);
      chk("fault flag", v[ST_BUSFAULT], 1'b1);
      chk("master bus flag", v[ST_MASTBUS], 1'b1);
      hold_low <= 1'b0;
      $display("low time-out test done");
      wr(OFS_CTRL, 32'h1000_0016);
      frame <= 1'b1;
      repeat (100) @(posedge clk_sys);
      frame <= 1'b0;
      hold_low <= 1'b1;
      repeat (100) @(posedge clk_sys);
      #1 chk("idle forced", bus_idle, 1'b1);
      hold_low <= 1'b0;
      $display("idle time-out test done");
      wrap_up();
   end
endmodule
